// file: logic/rtcal_pkg.sv
/*
 * Constants shared by the alarm and non-volatile commit block of the clock.
 * Assumes a 20 MHz system clock and a byte-wide register port from the
 * serial protocol engine.
 */
`default_nettype none
package rtcal_pkg;
    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_MHZ = 20;
    localparam int LOCKOUT_MS = 90;
    localparam int LOCKOUT_CYC = LOCKOUT_MS * 1000 * CLK_MHZ;
    localparam int IRQ_PULSE_NS = 250;
    localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [2:0] IRQ_PULSE_LAST = 3'(IRQ_PULSE_CYC);
    localparam int LOCK_W = 21;

    // ****************************************************************
    // Alarm register map (16 bytes, two sets of 8)
    // ****************************************************************
    localparam logic [3:0] ADDR_ALARM0_SECONDS = 4'h0;
    localparam logic [3:0] ADDR_ALARM0_MINUTES = 4'h1;
    localparam logic [3:0] ADDR_ALARM0_DAY_OF_WEEK = 4'h6;
    localparam logic [3:0] ADDR_ALARM0_CENTURY = 4'h7;
    localparam logic [3:0] ADDR_ALARM1_SECONDS = 4'h8;
    localparam logic [3:0] ADDR_ALARM1_DAY_OF_WEEK = 4'hE;
    localparam logic [2:0] SET_COMMIT_LAST = 3'h4;
    localparam int SET_BIT = 3;
    localparam int ALARM_BYTES = 16;
    localparam logic [7:0] ALARM_RESET = 8'h00;

    // ****************************************************************
    // Field layout inside an alarm byte and the time vector
    // ****************************************************************
    localparam int FIELD_EN_BIT = 7;
    localparam int CMP_FIELDS = 7;
    localparam int BYTE_W = 8;
endpackage : rtcal_pkg
`default_nettype wire

// file: logic/rtcal_alarm.sv
/*
 * Alarm compare, status flags, shared open-drain interrupt / clock-out pin,
 * non-volatile commit decision, bus lockout and power control bits.
 * Assumes the protocol engine delivers byte writes, a stop strobe and the
 * status-read strobe on mclk_i, and that the time vector is stable at tick.
 */
`timescale 1ns/1ns
`default_nettype none
// Function
// RL1 - Match sets flag regardless of interrupt enable
// RL2 - Status read eighth clock clears both flags
// RL3 - Host selects single mode: enable, pulse off
// RL4 - Single mode: pin low until flag read
// RL5 - Either alarm asserts pin; clear before reassert
// RL6 - Separate flags show which alarm fired
// RL7 - Pulse mode: one pulse every match
// RL8 - Pulse mode, both enabled: only alarm zero
// RL9 - Pulsing continues until mode or enables cleared
// RL10 - Single write to day-of-week never commits
// RL11 - Write ending on century byte never commits
// RL12 - Write ending on first five bytes commits
// RL13 - Host page write from alarm0 minutes, wraps
// RL14 - Alternative page write from alarm1 minutes
// RL15 - Commit day-of-week via three-byte write
// RL16 - Serial bus locked about 90 ms after brownout
// RL17 - Switchover select: zero standard, legacy default
// RL18 - Backup bus disable governs bus in backup
// RL19 - Disable bit one turns bus off in backup
// RL20 - Alarm pin only when frequency selects zero
// RL21 - One compare per time update
module rtcal_alarm
    import rtcal_pkg::*;
#(
    parameter int LOCK_CYCLES = LOCKOUT_CYC
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Running time
    input wire logic time_tick_i,
    input wire logic [63:0] time_i,
    // Register port from the protocol engine
    input wire logic reg_wr_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic wr_stop_i,
    input wire logic [3:0] reg_rd_addr_i,
    output logic [7:0] reg_rdata_o,
    input wire logic status_read_i,
    // Interrupt control bits
    input wire logic alarm_zero_enable_i,
    input wire logic alarm_one_enable_i,
    input wire logic pulse_mode_select_i,
    input wire logic freq_out_sel_hi_i,
    input wire logic freq_out_sel_lo_i,
    input wire logic fout_clk_i,
    // Power register bits and supply events
    input wire logic switchover_mode_select_i,
    input wire logic backup_bus_disable_i,
    input wire logic battery_backup_i,
    input wire logic brownout_i,
    // Status and outputs
    output logic alarm_zero_flag_o,
    output logic alarm_one_flag_o,
    output logic interrupt_or_clock_out_o,
    output logic interrupt_or_clock_out_oe_o,
    output logic nv_write_start_o,
    output logic bus_enable_o,
    output logic standard_switchover_o
);
    // ****************************************************************
    // Alarm storage
    // ****************************************************************
    logic [7:0] alarm_mem_ff [ALARM_BYTES];

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            for (int i = 0; i < ALARM_BYTES; i++) begin
                alarm_mem_ff[i] <= ALARM_RESET;
            end
        end else if (reg_wr_i) begin
            alarm_mem_ff[reg_addr_i] <= reg_wdata_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            reg_rdata_o <= ALARM_RESET;
        end else begin
            reg_rdata_o <= alarm_mem_ff[reg_rd_addr_i];
        end
    end

    // ****************************************************************
    // Compare
    // ****************************************************************
    // A field takes part only when its enable bit is set; an alarm with no
    // field enabled never matches, so a blank set stays quiet.
    logic [CMP_FIELDS-1:0] fld_ok0, fld_ok1, fld_on0, fld_on1;
    genvar g;
    generate
        for (g = 0; g < CMP_FIELDS; g++) begin : g_cmp
            assign fld_on0[g] = alarm_mem_ff[g][FIELD_EN_BIT];
            assign fld_on1[g] = alarm_mem_ff[g+BYTE_W][FIELD_EN_BIT];
            assign fld_ok0[g] = !fld_on0[g] ||
                (alarm_mem_ff[g][6:0] == time_i[g*BYTE_W +: 7]);
            assign fld_ok1[g] = !fld_on1[g] ||
                (alarm_mem_ff[g+BYTE_W][6:0] == time_i[g*BYTE_W +: 7]);
        end
    endgenerate

    logic match0, match1;
    assign match0 = time_tick_i && (&fld_ok0) && (|fld_on0); // RL21
    assign match1 = time_tick_i && (&fld_ok1) && (|fld_on1); // RL21

    // ****************************************************************
    // Status flags
    // ****************************************************************
    // Set wins over the clear so a match in the read cycle is not lost.
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            alarm_zero_flag_o <= 1'b0;
            alarm_one_flag_o <= 1'b0;
        end else begin
            alarm_zero_flag_o <= match0 || (alarm_zero_flag_o && !status_read_i); // RL1 RL2 RL6
            alarm_one_flag_o <= match1 || (alarm_one_flag_o && !status_read_i); // RL1 RL2 RL6
        end
    end

    // ****************************************************************
    // Interrupt pin
    // ****************************************************************
    logic alarm_pin_mode, single_fire, pulse_fire, irq_latch_ff;
    logic [2:0] pulse_cnt_ff;
    logic fout_s1_ff, fout_s2_ff;

    assign alarm_pin_mode = !freq_out_sel_hi_i && !freq_out_sel_lo_i; // RL20
    assign single_fire = alarm_pin_mode && !pulse_mode_select_i &&
        ((match0 && alarm_zero_enable_i) || (match1 && alarm_one_enable_i)); // RL4 RL5
    assign pulse_fire = alarm_pin_mode && pulse_mode_select_i &&
        ((match0 && alarm_zero_enable_i) ||
         (match1 && alarm_one_enable_i && !alarm_zero_enable_i)); // RL7 RL8 RL9

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            irq_latch_ff <= 1'b0;
        end else begin
            irq_latch_ff <= single_fire || (irq_latch_ff && !status_read_i); // RL4 RL5
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pulse_cnt_ff <= 3'h0;
        end else if (pulse_fire) begin
            pulse_cnt_ff <= IRQ_PULSE_LAST; // RL7
        end else if (pulse_cnt_ff != 3'h0) begin
            pulse_cnt_ff <= pulse_cnt_ff - 3'h1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            fout_s1_ff <= 1'b1;
            fout_s2_ff <= 1'b1;
        end else begin
            fout_s1_ff <= fout_clk_i;
            fout_s2_ff <= fout_s1_ff;
        end
    end

    // Open drain: the pin value is always low, only the enable moves.
    assign interrupt_or_clock_out_o = 1'b0;
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            interrupt_or_clock_out_oe_o <= 1'b0;
        end else if (alarm_pin_mode) begin
            interrupt_or_clock_out_oe_o <= irq_latch_ff || (pulse_cnt_ff != 3'h0); // RL20
        end else begin
            interrupt_or_clock_out_oe_o <= !fout_s2_ff; // RL20
        end
    end

    // ****************************************************************
    // Non-volatile commit
    // ****************************************************************
    // Only the last byte of a write decides; the day-of-week and century
    // bytes lie outside the first five of a set and so never commit.
    logic wr_seen_ff;
    logic [3:0] last_addr_ff;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            wr_seen_ff <= 1'b0;
            last_addr_ff <= ADDR_ALARM0_SECONDS;
        end else if (reg_wr_i) begin
            wr_seen_ff <= 1'b1;
            last_addr_ff <= reg_addr_i;
        end else if (wr_stop_i) begin
            wr_seen_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            nv_write_start_o <= 1'b0;
        end else begin
            nv_write_start_o <= wr_stop_i && wr_seen_ff &&
                (last_addr_ff[2:0] <= SET_COMMIT_LAST); // RL10 RL11 RL12
        end
    end

    // ****************************************************************
    // Bus lockout and power control
    // ****************************************************************
    logic brown_s1_ff, brown_s2_ff, bat_s1_ff, bat_s2_ff;
    logic [LOCK_W-1:0] lock_cnt_ff;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            brown_s1_ff <= 1'b0;
            brown_s2_ff <= 1'b0;
            bat_s1_ff <= 1'b0;
            bat_s2_ff <= 1'b0;
        end else begin
            brown_s1_ff <= brownout_i;
            brown_s2_ff <= brown_s1_ff;
            bat_s1_ff <= battery_backup_i;
            bat_s2_ff <= bat_s1_ff;
        end
    end

    // The count restarts while the brownout level is held, so the lockout
    // runs from the end of the slow ramp.
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            lock_cnt_ff <= '0;
        end else if (brown_s2_ff) begin
            lock_cnt_ff <= LOCK_W'(LOCK_CYCLES); // RL16
        end else if (lock_cnt_ff != '0) begin
            lock_cnt_ff <= lock_cnt_ff - LOCK_W'(1);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            bus_enable_o <= 1'b1;
            standard_switchover_o <= 1'b0;
        end else begin
            bus_enable_o <= (lock_cnt_ff == '0) && !brown_s2_ff &&
                !(bat_s2_ff && backup_bus_disable_i); // RL16 RL18 RL19
            standard_switchover_o <= !switchover_mode_select_i; // RL17
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    property p_flag_set;
        match0 |=> alarm_zero_flag_o;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag0 not set"); // RL1

    property p_flag_clear;
        status_read_i && !match0 && !match1 |=> !alarm_zero_flag_o && !alarm_one_flag_o;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared"); // RL2

    property p_single_hold;
        single_fire ##1 (!status_read_i && alarm_pin_mode) |=> interrupt_or_clock_out_oe_o;
    endproperty
    a_single_hold: assert property (p_single_hold) else $error("pin not held"); // RL4

    property p_one_flag_sep;
        match1 && !match0 && !alarm_zero_flag_o && !status_read_i |=> !alarm_zero_flag_o;
    endproperty
    a_one_flag_sep: assert property (p_one_flag_sep) else $error("flags mixed"); // RL6

    property p_pulse;
        pulse_fire && !irq_latch_ff ##1 (alarm_pin_mode && !irq_latch_ff)
            |=> interrupt_or_clock_out_oe_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("no pulse"); // RL7

    property p_pulse_one_only;
        pulse_mode_select_i && alarm_zero_enable_i && match1 && !match0 &&
            (pulse_cnt_ff == 3'h0) |=> (pulse_cnt_ff == 3'h0);
    endproperty
    a_pulse_one_only: assert property (p_pulse_one_only) else $error("alarm1 pulsed"); // RL8

    property p_no_commit_high;
        wr_stop_i && (last_addr_ff[2:0] > SET_COMMIT_LAST) |=> !nv_write_start_o;
    endproperty
    a_no_commit_high: assert property (p_no_commit_high) else $error("bad commit"); // RL10 RL11

    property p_commit;
        wr_stop_i && wr_seen_ff && (last_addr_ff[2:0] <= SET_COMMIT_LAST) |=> nv_write_start_o;
    endproperty
    a_commit: assert property (p_commit) else $error("commit missing"); // RL12

    property p_lockout;
        $fell(brown_s2_ff) |-> ##1 !bus_enable_o [*4];
    endproperty
    a_lockout: assert property (p_lockout) else $error("bus not locked"); // RL16

    property p_backup_off;
        bat_s2_ff && backup_bus_disable_i |=> !bus_enable_o;
    endproperty
    a_backup_off: assert property (p_backup_off) else $error("bus on in backup"); // RL19

    property p_switch;
        ##1 standard_switchover_o == !$past(switchover_mode_select_i);
    endproperty
    a_switch: assert property (p_switch) else $error("switchover wrong"); // RL17

    property p_fout;
        !alarm_pin_mode |=> interrupt_or_clock_out_oe_o == !$past(fout_s2_ff);
    endproperty
    a_fout: assert property (p_fout) else $error("alarm in fout mode"); // RL20
endmodule : rtcal_alarm
`default_nettype wire

// file: test/rtcal_host.sv
/*
 * Host-side model: register port of the protocol engine and the pulled-up
 * open-drain alarm pin. Assumes the bench calls its tasks at posedge + 1 ns.
 */
`timescale 1ns/1ns
`default_nettype none
module rtcal_host (
    // Clock
    input wire logic mclk_i,
    // Register port towards the block
    output logic reg_wr_o,
    output logic [3:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic wr_stop_o,
    output logic status_read_o,
    // Open-drain pin
    input wire logic irq_oe_i,
    output logic irq_pin_o
);
    // Pull-up wins whenever nobody pulls low
    assign irq_pin_o = irq_oe_i ? 1'b0 : 1'b1;
    initial begin
        {reg_wr_o, wr_stop_o, status_read_o} = 3'h0;
        reg_addr_o = 4'h0;
        reg_wdata_o = 8'h00;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_wr_o = 1'b1;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(posedge mclk_i);
        #1;
        reg_wr_o = 1'b0;
        // Released bus no longer shows the last byte
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
        @(posedge mclk_i);
        #1;
    endtask : wr
    // Page write wraps inside the 16-byte alarm page
    task automatic page(input logic [3:0] start, input int n, input logic [7:0] d);
        for (int i = 0; i < n; i++) begin
            wr(start + 4'(i), d);
        end
    endtask : page
    task automatic stop();
        wr_stop_o = 1'b1;
        @(posedge mclk_i);
        #1;
        wr_stop_o = 1'b0;
    endtask : stop
    task automatic status_rd();
        status_read_o = 1'b1;
        @(posedge mclk_i);
        #1;
        status_read_o = 1'b0;
    endtask : status_rd
endmodule : rtcal_host
`default_nettype wire

// file: test/testbench.sv
/*
 * Self-checking bench for the alarm block with the host model.
 * Assumes a shortened lockout count and only seconds fields enabled.
 */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import rtcal_pkg::*;
    localparam int LOCK_SIM = 20;
    logic mclk_i = 1'b0, reset_i = 1'b1, time_tick_i = 1'b0, fout_clk_i = 1'b1;
    logic alarm_zero_enable_i = 1'b0, alarm_one_enable_i = 1'b0, pulse_mode_select_i = 1'b0;
    logic freq_out_sel_hi_i = 1'b0, freq_out_sel_lo_i = 1'b0, switchover_mode_select_i = 1'b1;
    logic backup_bus_disable_i = 1'b0, battery_backup_i = 1'b0, brownout_i = 1'b0;
    logic [63:0] time_i = '0;
    logic [3:0] reg_rd_addr_i = 4'h6;
    logic reg_wr_i, wr_stop_i, status_read_i, alarm_zero_flag_o, alarm_one_flag_o;
    logic interrupt_or_clock_out_o, interrupt_or_clock_out_oe_o, nv_write_start_o;
    logic bus_enable_o, standard_switchover_o, pin;
    logic [3:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o;
    int mismatches = 0, checks = 0, c;
    rtcal_alarm #(.LOCK_CYCLES(LOCK_SIM)) dut (.mclk_i(mclk_i), .reset_i(reset_i),
        .time_tick_i(time_tick_i), .time_i(time_i), .reg_wr_i(reg_wr_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .wr_stop_i(wr_stop_i),
        .reg_rd_addr_i(reg_rd_addr_i), .reg_rdata_o(reg_rdata_o),
        .status_read_i(status_read_i), .alarm_zero_enable_i(alarm_zero_enable_i),
        .alarm_one_enable_i(alarm_one_enable_i), .pulse_mode_select_i(pulse_mode_select_i),
        .freq_out_sel_hi_i(freq_out_sel_hi_i), .freq_out_sel_lo_i(freq_out_sel_lo_i),
        .fout_clk_i(fout_clk_i), .switchover_mode_select_i(switchover_mode_select_i),
        .backup_bus_disable_i(backup_bus_disable_i), .battery_backup_i(battery_backup_i),
        .brownout_i(brownout_i), .alarm_zero_flag_o(alarm_zero_flag_o),
        .alarm_one_flag_o(alarm_one_flag_o),
        .interrupt_or_clock_out_o(interrupt_or_clock_out_o),
        .interrupt_or_clock_out_oe_o(interrupt_or_clock_out_oe_o),
        .nv_write_start_o(nv_write_start_o), .bus_enable_o(bus_enable_o),
        .standard_switchover_o(standard_switchover_o));
    rtcal_host host (.mclk_i(mclk_i), .reg_wr_o(reg_wr_i), .reg_addr_o(reg_addr_i),
        .reg_wdata_o(reg_wdata_i), .wr_stop_o(wr_stop_i), .status_read_o(status_read_i),
        .irq_oe_i(interrupt_or_clock_out_oe_o), .irq_pin_o(pin));
    always #25 mclk_i = ~mclk_i;
    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : cyc
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int s, input int w);
        time_i[7:0] = 8'(s);
        time_tick_i = 1'b1;
        cyc(1);
        time_tick_i = 1'b0;
        cyc(w);
    endtask : tick
    task automatic count_oe(input int n);
        c = 0;
        repeat (n) begin
            cyc(1);
            c += int'(interrupt_or_clock_out_oe_o === 1'b1);
        end
    endtask : count_oe
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_commit();
        int tb [9][3] = '{'{6, 1, 0}, '{7, 1, 0}, '{4, 1, 1}, '{12, 1, 1}, '{1, 16, 1},
            '{9, 16, 1}, '{6, 3, 1}, '{0, 8, 0}, '{5, 0, 0}};
        check(reg_rdata_o, ALARM_RESET);
        foreach (tb[i]) begin
            host.page(4'(tb[i][0]), tb[i][1], 8'h00);
            host.stop();
            count_oe(0);
            c = 0;
            repeat (4) begin
                c += int'(nv_write_start_o === 1'b1);
                cyc(1);
            end
            check(8'(c), 8'(tb[i][2]));
        end
        host.wr(ADDR_ALARM0_SECONDS, 8'h85);
        host.wr(ADDR_ALARM1_SECONDS, 8'h87);
        reg_rd_addr_i = ADDR_ALARM0_SECONDS;
        cyc(2);
        check(reg_rdata_o, 8'h85);
        $display("test commit done");
    endtask : t_commit
    task automatic t_single();
        alarm_zero_enable_i = 1'b1;
        tick(5, 3);
        check(8'(alarm_zero_flag_o), 8'h01);
        check(8'(alarm_one_flag_o), 8'h00);
        cyc(6);
        check(8'(pin), 8'h00);
        host.status_rd();
        cyc(2);
        check(8'({alarm_one_flag_o, alarm_zero_flag_o, pin}), 8'h01);
        cyc(5);
        check(8'(alarm_zero_flag_o), 8'h00);
        alarm_zero_enable_i = 1'b0;
        tick(5, 3);
        check(8'({alarm_zero_flag_o, pin}), 8'h03);
        alarm_zero_enable_i = 1'b1;
        alarm_one_enable_i = 1'b1;
        host.status_rd();
        tick(7, 3);
        check(8'({alarm_one_flag_o, alarm_zero_flag_o, pin}), 8'h04);
        tick(5, 3);
        check(8'(alarm_zero_flag_o), 8'h01);
        host.status_rd();
        cyc(2);
        check(8'(pin), 8'h01);
        $display("test single done");
    endtask : t_single
    task automatic t_pulse();
        int tb [4][3] = '{'{1, 0, 5}, '{1, 0, 5}, '{0, 1, 7}, '{1, 1, 5}};
        pulse_mode_select_i = 1'b1;
        foreach (tb[i]) begin
            {alarm_zero_enable_i, alarm_one_enable_i} = {1'(tb[i][0]), 1'(tb[i][1])};
            tick(tb[i][2], 0);
            count_oe(12);
            check(8'(c), 8'(IRQ_PULSE_CYC));
        end
        tick(7, 0);
        count_oe(12);
        check(8'(c), 8'h00);
        check(8'(alarm_one_flag_o), 8'h01);
        {alarm_zero_enable_i, alarm_one_enable_i} = 2'h0;
        tick(5, 0);
        count_oe(12);
        check(8'(c), 8'h00);
        host.status_rd();
        pulse_mode_select_i = 1'b0;
        $display("test pulse done");
    endtask : t_pulse
    task automatic t_fout();
        alarm_zero_enable_i = 1'b1;
        for (int k = 1; k < 4; k++) begin
            {freq_out_sel_hi_i, freq_out_sel_lo_i} = 2'(k);
            fout_clk_i = 1'b0;
            cyc(4);
            check(8'(interrupt_or_clock_out_oe_o), 8'h01);
            check(8'(interrupt_or_clock_out_o), 8'h00);
            fout_clk_i = 1'b1;
            tick(5, 4);
            check(8'(interrupt_or_clock_out_oe_o), 8'h00);
        end
        {freq_out_sel_hi_i, freq_out_sel_lo_i} = 2'h0;
        cyc(3);
        check(8'(pin), 8'h01);
        host.status_rd();
        $display("test fout done");
    endtask : t_fout
    task automatic t_power();
        check(8'(standard_switchover_o), 8'h00);
        switchover_mode_select_i = 1'b0;
        battery_backup_i = 1'b1;
        cyc(5);
        check(8'({standard_switchover_o, bus_enable_o}), 8'h03);
        backup_bus_disable_i = 1'b1;
        cyc(5);
        check(8'(bus_enable_o), 8'h00);
        battery_backup_i = 1'b0;
        brownout_i = 1'b1;
        cyc(6);
        check(8'(bus_enable_o), 8'h00);
        brownout_i = 1'b0;
        cyc(LOCK_SIM - 4);
        check(8'(bus_enable_o), 8'h00);
        c = 0;
        while (bus_enable_o !== 1'b1 && c < 20) begin
            cyc(1);
            c++;
        end
        check(8'(bus_enable_o), 8'h01);
        check(8'(c + LOCK_SIM - 4), 8'(LOCK_SIM + 3));
        $display("test power done");
    endtask : t_power
    initial begin
        cyc(2);
        reset_i = 1'b0;
        cyc(1);
        t_commit();
        t_single();
        t_pulse();
        t_fout();
        t_power();
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
